// ### design/crs_core_regs.sv
// crs_core_regs.sv: program counter, accumulator, index, stack pointer
// and flag register of the 8-bit cpu core, plus an avalon-mm slave for
// a small control and status window. assumes the execution logic runs
// on CLK and presents one update bundle per cycle.
`timescale 1ns/100ps
`default_nettype none
`include "crs_defines.svh"

// Overview of operation
// RQ1 - high and low pc bytes join into one 16-bit program address.
// RQ2 - program space is flat; fetch address needs no paging or banking.
// RQ3 - arithmetic or logic results of source modes go to the accumulator.
// RQ4 - an 8-bit index value supplies the offset for indexed modes.
// RQ5 - stack pointer holds top of stack; push, pop, call, returns move it.
// RQ6 - flag bit 0 enables interrupts; only logical flag writes change it.
// RQ7 - flag bit 1 set on zero result of last operation, else cleared.
// RQ8 - flag bit 2 set on carry of last operation, else cleared.
// RQ9 - flag bit 4 selects register bank; changed only by flag writes.
// RQ10 - flag bit 3 follows supervisor state; software writes ignored.
// RQ11 - flags update on arithmetic, logic, shift as the instruction says.
// RQ12 - software cannot read or write the six core registers directly.
// RQ13 - indexed effective address is operand byte plus index register.
// RQ14 - both pc bytes clear at reset so execution starts at zero.
// RQ15 - reset clears a, x, sp and flags, but sets the zero flag.
module crs_core_regs
    import crs_pkg::*;
#(
    parameter int PROG_BYTES = `CRS_PROG_BYTES,
    parameter logic [31:0] ID_VALUE = `CRS_ID_VALUE // arbitrary value
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire crs_exec_t EXEC,
    input wire logic SUPERVISOR,
    input wire logic [7:0] OPERAND,
    output logic [15:0] PROG_ADDR,
    output logic [7:0] ACC,
    output logic [7:0] INDEX,
    output logic [7:0] STACK_PTR,
    output logic [7:0] FLAGS,
    output logic [7:0] EFF_ADDR,
    output logic IRQ_ENABLE,
    output logic BANK_SEL,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] program_counter_high;
    logic [7:0] program_counter_low;
    logic [7:0] accumulator_reg;
    logic [7:0] index_reg;
    logic [7:0] stack_pointer_reg;
    logic [7:0] cpu_flags;
    logic [7:0] eff_addr_reg;
    logic hold_reg;
    logic stkerr_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [15:0] pc_next;
    logic [7:0] sp_next;
    logic [7:0] flags_next;
    logic run;
    logic stk_fault;
    logic bus_req;
    logic bus_ack;
    logic bus_done;

    // hold freezes pc, accumulator, index, stack pointer and flags so a debugger sees stable state
    assign run = !hold_reg;
    assign bus_req = AVS_READ || AVS_WRITE;
    assign bus_ack = bus_req && wait_reg;
    // writes commit on the edge at which the master sees waitrequest low
    assign bus_done = bus_req && !wait_reg;

    // ------------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------------
    // 16-bit wrap keeps the space flat; no page register exists
    always_comb begin
        pc_next = {program_counter_high, program_counter_low}; // see RQ1
        if (EXEC.pc_load) begin
            pc_next = EXEC.pc_value;
        end else if (EXEC.pc_inc) begin
            pc_next = pc_next + 16'h0001; // see RQ2
        end
    end

    // clears to address zero at reset
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            program_counter_high <= 8'(`CRS_PC_RESET >> 8); // see RQ14
            program_counter_low <= 8'(`CRS_PC_RESET); // see RQ14
        end else if (run) begin
            program_counter_high <= pc_next[15:8];
            program_counter_low <= pc_next[7:0];
        end
    end

    // ------------------------------------------------------------------
    // accumulator and index
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            accumulator_reg <= `CRS_BYTE_RESET; // see RQ15
        end else if (run && EXEC.acc_we) begin
            accumulator_reg <= EXEC.acc_value; // see RQ3
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            index_reg <= `CRS_BYTE_RESET; // see RQ15
        end else if (run && EXEC.idx_we) begin
            index_reg <= EXEC.idx_value; // see RQ4
        end
    end

    // effective address uses the index held now; carry out is dropped
    // because the data space is 8 bits wide
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            eff_addr_reg <= `CRS_BYTE_RESET;
        end else begin
            eff_addr_reg <= OPERAND + index_reg; // see RQ13
        end
    end

    // ------------------------------------------------------------------
    // stack pointer
    // ------------------------------------------------------------------
    // push grows upward; a call pushes two bytes, a return pops them
    always_comb begin
        sp_next = stack_pointer_reg;
        stk_fault = 1'b0;
        unique case (EXEC.sp_op)
            CRS_SP_NONE: sp_next = stack_pointer_reg;
            CRS_SP_PUSH: begin
                sp_next = stack_pointer_reg + {6'h00, EXEC.sp_bytes};
                stk_fault = sp_next < stack_pointer_reg;
            end
            CRS_SP_POP: begin
                sp_next = stack_pointer_reg - {6'h00, EXEC.sp_bytes};
                stk_fault = sp_next > stack_pointer_reg;
            end
            CRS_SP_LOAD: sp_next = EXEC.sp_value;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            stack_pointer_reg <= `CRS_BYTE_RESET; // see RQ15
        end else if (run) begin
            stack_pointer_reg <= sp_next; // see RQ5
        end
    end

    // ------------------------------------------------------------------
    // flag register
    // ------------------------------------------------------------------
    // a logical write to the flags wins over the alu result of the same
    // instruction; the supervisor bit never comes from software
    always_comb begin
        flags_next = cpu_flags;
        if (EXEC.flag_we) begin
            flags_next = EXEC.flag_value & `CRS_F_SW_MASK; // see RQ6 RQ9
        end else if (EXEC.alu_valid) begin
            if (EXEC.zero_upd) begin
                flags_next[`CRS_F_ZERO] = EXEC.alu_result == 8'h00; // see RQ7
            end
            if (EXEC.carry_upd) begin
                flags_next[`CRS_F_CARRY] = EXEC.alu_carry; // see RQ8 RQ11
            end
        end
        flags_next[`CRS_F_SUPER] = SUPERVISOR; // see RQ10
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cpu_flags <= `CRS_F_RESET; // see RQ15
        end else if (run) begin
            cpu_flags <= flags_next;
        end
    end

    // ------------------------------------------------------------------
    // avalon slave: control, status, id only
    // ------------------------------------------------------------------
    // waitrequest idles high and drops for exactly one cycle per access
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !bus_ack;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            hold_reg <= 1'b0;
        end else if (bus_done && AVS_WRITE && AVS_ADDRESS == `CRS_OFS_CTRL
                     && AVS_BYTEENABLE[0]) begin
            hold_reg <= AVS_WRITEDATA[`CRS_CTRL_HOLD];
        end
    end

    // sticky stack fault; a new fault wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            stkerr_reg <= 1'b0;
        end else if (run && stk_fault) begin
            stkerr_reg <= 1'b1;
        end else if (bus_done && AVS_WRITE && AVS_ADDRESS == `CRS_OFS_STAT
                     && AVS_BYTEENABLE[1]
                     && AVS_WRITEDATA[`CRS_STAT_STKERR]) begin
            stkerr_reg <= 1'b0;
        end
    end

    // core registers have no address here at all; unmapped reads give 0
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_ack && AVS_READ) begin
            unique case (AVS_ADDRESS)
                `CRS_OFS_CTRL: rdata_reg <= {31'h0000_0000, hold_reg};
                `CRS_OFS_STAT: rdata_reg <= {23'h00_0000, stkerr_reg,
                                             8'h00}; // see RQ12
                `CRS_OFS_ID: rdata_reg <= ID_VALUE;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // program memory beyond PROG_BYTES aliases; the address stays 16 bit
    assign PROG_ADDR = {program_counter_high, program_counter_low};
    assign ACC = accumulator_reg;
    assign INDEX = index_reg;
    assign STACK_PTR = stack_pointer_reg;
    assign FLAGS = cpu_flags;
    assign EFF_ADDR = eff_addr_reg;
    assign IRQ_ENABLE = cpu_flags[`CRS_F_IE];
    assign BANK_SEL = cpu_flags[`CRS_F_BANK];
    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking chk_cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_pc_step;
        run && !EXEC.pc_load && EXEC.pc_inc;
    endsequence

    sequence s_push;
        run && EXEC.sp_op == CRS_SP_PUSH;
    endsequence

    sequence s_pop;
        run && EXEC.sp_op == CRS_SP_POP;
    endsequence

    sequence s_access;
        bus_req && wait_reg ##1 !wait_reg;
    endsequence

    chk_pc_step: assert property ( // see RQ1
        s_pc_step |=> PROG_ADDR == $past(PROG_ADDR) + 16'h0001)
        else $error("pc did not step by one");

    chk_pc_load: assert property ( // see RQ2
        run && EXEC.pc_load |=> PROG_ADDR == $past(EXEC.pc_value))
        else $error("pc load lost");

    chk_acc_write: assert property ( // see RQ3
        run && EXEC.acc_we |=> ACC == $past(EXEC.acc_value))
        else $error("accumulator not written");

    chk_eff_addr: assert property ( // see RQ13
        ##1 EFF_ADDR == 8'($past(OPERAND) + $past(INDEX)))
        else $error("effective address wrong");

    chk_sp_push: assert property ( // see RQ5
        s_push |=> STACK_PTR ==
            8'($past(STACK_PTR) + {6'h00, $past(EXEC.sp_bytes)}))
        else $error("push did not move stack pointer");

    chk_zero_flag: assert property ( // see RQ7
        run && !EXEC.flag_we && EXEC.alu_valid && EXEC.zero_upd
        |=> FLAGS[`CRS_F_ZERO] == ($past(EXEC.alu_result) == 8'h00))
        else $error("zero flag wrong");

    chk_carry_flag: assert property ( // see RQ8
        run && !EXEC.flag_we && EXEC.alu_valid && EXEC.carry_upd
        |=> FLAGS[`CRS_F_CARRY] == $past(EXEC.alu_carry))
        else $error("carry flag wrong");

    chk_ie_bank: assert property ( // see RQ6
        !EXEC.flag_we |=> $stable({IRQ_ENABLE, BANK_SEL}))
        else $error("ie or bank changed without flag write");

    chk_super_bit: assert property ( // see RQ10
        run |=> FLAGS[`CRS_F_SUPER] == $past(SUPERVISOR)
            && FLAGS[7:5] == 3'h0)
        else $error("supervisor bit not tracking");

    chk_bus_answer: assert property ( // see RQ12
        s_access |-> ##1 wait_reg)
        else $error("waitrequest low longer than one cycle");

    chk_sp_pop: assert property ( // see RQ5
        s_pop |=> STACK_PTR ==
            8'($past(STACK_PTR) - {6'h00, $past(EXEC.sp_bytes)}))
        else $error("pop did not move stack pointer");

    chk_flag_write: assert property ( // see RQ9
        run && EXEC.flag_we |=> (FLAGS & `CRS_F_SW_MASK) ==
            ($past(EXEC.flag_value) & `CRS_F_SW_MASK))
        else $error("logical flag write lost");

    // hold must freeze every core register; bus traffic alone never
    // reaches them
    chk_hold_freeze: assert property ( // see RQ12
        !run |=> $stable(PROG_ADDR) && $stable(ACC) && $stable(INDEX)
            && $stable(STACK_PTR) && $stable(FLAGS))
        else $error("core register moved while held");

    // reset values are judged during reset itself, so never disabled
    chk_reset_state: assert property ( // see RQ14 RQ15
        disable iff (1'b0)
        !RESETN |=> PROG_ADDR == `CRS_PC_RESET && FLAGS == `CRS_F_RESET
            && {ACC, INDEX, STACK_PTR} == 24'h00_0000)
        else $error("reset state wrong");

endmodule : crs_core_regs
`default_nettype wire

// ### design/crs_defines.svh
// crs_defines.svh: offsets, field positions, reset values and counts
// for the cpu core register set; assumes inclusion by bare name.
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
// ----------------------------------------------------------------------
// avalon register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CRS_OFS_CTRL 8'h00
`define CRS_OFS_STAT 8'h04
`define CRS_OFS_ID 8'h08
// ----------------------------------------------------------------------
// flag register fields
// ----------------------------------------------------------------------
`define CRS_F_IE 0
`define CRS_F_ZERO 1
`define CRS_F_CARRY 2
`define CRS_F_SUPER 3
`define CRS_F_BANK 4
`define CRS_F_SW_MASK 8'h17
`define CRS_F_RESET 8'h02
// ----------------------------------------------------------------------
// other reset values and fields
// ----------------------------------------------------------------------
`define CRS_PC_RESET 16'h0000
`define CRS_BYTE_RESET 8'h00
`define CRS_CTRL_HOLD 0
`define CRS_STAT_STKERR 8
`define CRS_PROG_BYTES 16384
`define CRS_ID_VALUE 32'h0000_5A01 // arbitrary value
`endif

// ### design/crs_pkg.sv
// crs_pkg.sv: types shared by the cpu core register set
// assumes a single cpu clock; no constants live here, only types.
package crs_pkg;
    // stack pointer operation requested by the execution logic
    typedef enum logic [1:0] {
        CRS_SP_NONE,
        CRS_SP_PUSH,
        CRS_SP_POP,
        CRS_SP_LOAD
    } crs_sp_op_t;

    // one instruction's worth of register updates
    typedef struct packed {
        logic pc_load;
        logic pc_inc;
        logic [15:0] pc_value;
        logic acc_we;
        logic [7:0] acc_value;
        logic idx_we;
        logic [7:0] idx_value;
        crs_sp_op_t sp_op;
        logic [1:0] sp_bytes;
        logic [7:0] sp_value;
        logic alu_valid;
        logic zero_upd;
        logic carry_upd;
        logic [7:0] alu_result;
        logic alu_carry;
        logic flag_we;
        logic [7:0] flag_value;
    } crs_exec_t;
endpackage : crs_pkg

// ### tb/cpu_core_register_set_tb_top.sv
// cpu_core_register_set_tb_top.sv: self-checking bench for the set
// assumes the execution model file and the design files are compiled.
`timescale 1ns/100ps
`default_nettype none
module cpu_core_register_set_tb_top
    import crs_pkg::*;
;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    localparam logic [31:0] TB_ID = 32'h0000_3C5E; // arbitrary value
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    crs_exec_t EXEC;
    logic SUPERVISOR, AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST;
    logic IRQ_ENABLE, BANK_SEL;
    logic [7:0] OPERAND, ACC, INDEX, STACK_PTR, FLAGS, EFF_ADDR;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic [15:0] PROG_ADDR;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    int bad_count = 0;
    int checks = 0;

    // 25 ns period
    initial begin
        forever #12.5 CLK = ~CLK;
    end

    crs_exec_model exe (.CLK(CLK), .EXEC(EXEC),
        .SUPERVISOR(SUPERVISOR), .OPERAND(OPERAND));

    crs_core_regs #(.ID_VALUE(TB_ID)) dut_u (.CLK(CLK), .RESETN(RESETN),
        .EXEC(EXEC), .SUPERVISOR(SUPERVISOR), .OPERAND(OPERAND),
        .PROG_ADDR(PROG_ADDR), .ACC(ACC), .INDEX(INDEX),
        .STACK_PTR(STACK_PTR), .FLAGS(FLAGS), .EFF_ADDR(EFF_ADDR),
        .IRQ_ENABLE(IRQ_ENABLE), .BANK_SEL(BANK_SEL),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST));

    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] x);
        checks++;
        if (s !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // request held until waitrequest is seen low at a rising edge;
    // only the watchdog ends a wait that never finishes
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        AVS_READ <= ~wr;
        AVS_WRITE <= wr;
        do begin
            @(posedge CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask : bus

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_pc();
        crs_exec_t e;
        e = '0;
        e.pc_load = 1'b1;
        e.pc_value = 16'h3FFF;
        exe.issue(e);
        @(negedge CLK);
        check("pc_load", 32'(PROG_ADDR), 32'h3FFF);
        e = '0;
        e.pc_inc = 1'b1;
        exe.issue(e);
        @(negedge CLK);
        check("pc_inc", 32'(PROG_ADDR), 32'h4000);
        e.pc_load = 1'b1;
        e.pc_value = 16'h0000;
        exe.issue(e);
        @(negedge CLK);
        check("pc_prio", 32'(PROG_ADDR), 32'h0);
        $display("test pc done");
    endtask : t_pc

    task automatic t_data();
        crs_exec_t e;
        e = '0;
        e.idx_we = 1'b1;
        e.idx_value = 8'hF0;
        exe.issue(e);
        @(negedge CLK);
        check("index", 32'(INDEX), 32'hF0);
        exe.set_mode(1'b0, 8'h20);
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        check("eff_addr", 32'(EFF_ADDR), 32'h10);
        e = '0;
        e.acc_we = 1'b1;
        e.acc_value = 8'hA5;
        exe.issue(e);
        @(negedge CLK);
        check("acc", 32'(ACC), 32'hA5);
        $display("test data done");
    endtask : t_data

    task automatic t_stack();
        crs_exec_t e;
        e = '0;
        e.sp_op = CRS_SP_PUSH;
        e.sp_bytes = 2'd2;
        exe.issue(e);
        @(negedge CLK);
        check("sp_push", 32'(STACK_PTR), 32'h02);
        e.sp_op = CRS_SP_POP;
        e.sp_bytes = 2'd1;
        exe.issue(e);
        @(negedge CLK);
        check("sp_pop", 32'(STACK_PTR), 32'h01);
        e.sp_bytes = 2'd2;
        exe.issue(e);
        @(negedge CLK);
        check("sp_wrap", 32'(STACK_PTR), 32'hFF);
        bus(1'b0, 8'h04, 32'h0, 4'hF);
        check("stk_fault", 32'(q[8]), 32'h1);
        bus(1'b1, 8'h04, 32'h100, 4'h2);
        bus(1'b0, 8'h04, 32'h0, 4'hF);
        check("stk_clear", 32'(q[8]), 32'h0);
        e.sp_op = CRS_SP_LOAD;
        e.sp_value = 8'h80;
        exe.issue(e);
        @(negedge CLK);
        check("sp_load", 32'(STACK_PTR), 32'h80);
        $display("test stack done");
    endtask : t_stack

    task automatic t_flags();
        exe.alu(8'h00, 1'b1, 1'b1, 1'b1);
        @(negedge CLK);
        check("zc_set", 32'(FLAGS), 32'h06);
        exe.alu(8'h5A, 1'b0, 1'b1, 1'b1);
        @(negedge CLK);
        check("zc_clr", 32'(FLAGS), 32'h00);
        exe.alu(8'h00, 1'b1, 1'b1, 1'b0);
        @(negedge CLK);
        check("zero_only", 32'(FLAGS), 32'h02);
        exe.flag_write(8'hFF);
        @(negedge CLK);
        check("flag_wr", 32'(FLAGS), 32'h17);
        check("irq_en", 32'(IRQ_ENABLE), 32'h1);
        check("bank", 32'(BANK_SEL), 32'h1);
        exe.set_mode(1'b1, 8'h20);
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        check("super", 32'(FLAGS), 32'h1F);
        exe.flag_write(8'h00);
        @(negedge CLK);
        check("super_keep", 32'(FLAGS), 32'h08);
        exe.set_mode(1'b0, 8'h20);
        $display("test flags done");
    endtask : t_flags

    task automatic t_bus();
        crs_exec_t e;
        bus(1'b0, 8'h08, 32'h0, 4'hF);
        check("id", q, TB_ID);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 8'h40, 32'h0, 4'hF);
        check("unmapped", q, 32'h0);
        bus(1'b1, 8'h00, 32'h1, 4'h1);
        bus(1'b0, 8'h00, 32'h0, 4'hF);
        check("hold_rd", 32'(q[0]), 32'h1);
        e = '0;
        e.acc_we = 1'b1;
        e.acc_value = 8'h3C;
        exe.issue(e);
        @(negedge CLK);
        check("held_acc", 32'(ACC), 32'hA5);
        bus(1'b1, 8'h00, 32'h0, 4'h1);
        @(negedge CLK);
        check("wait_idle", 32'(AVS_WAITREQUEST), 32'h1);
        exe.issue(e);
        @(negedge CLK);
        check("free_acc", 32'(ACC), 32'h3C);
        $display("test bus done");
    endtask : t_bus

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge CLK);
        RESETN <= 1'b1;
        @(negedge CLK);
        check("rst_pc", 32'(PROG_ADDR), 32'h0);
        check("rst_flags", 32'(FLAGS), 32'h02);
        check("rst_regs", {8'h0, ACC, INDEX, STACK_PTR}, 32'h0);
        check("rst_wait", 32'(AVS_WAITREQUEST), 32'h1);
        check("rst_rdata", AVS_READDATA, 32'h0);
        $display("test reset done");
        t_pc();
        t_data();
        t_stack();
        t_flags();
        t_bus();
        finish_test();
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge CLK);
        bad_count++;
        finish_test();
    end
endmodule : cpu_core_register_set_tb_top
`default_nettype wire

// ### tb/crs_exec_model.sv
// crs_exec_model.sv: behavioural execution logic for the register set
// assumes the register set samples EXEC at every rising CLK edge.
`timescale 1ns/100ps
`default_nettype none
module crs_exec_model
    import crs_pkg::*;
(
    input wire logic CLK,
    output crs_exec_t EXEC,
    output logic SUPERVISOR,
    output logic [7:0] OPERAND
);
    // idle bundle from time zero, so nothing moves before a request
    initial begin
        EXEC = '0;
        SUPERVISOR = 1'b0;
        OPERAND = 8'h00;
    end

    // one bundle for exactly one cycle; a later call waits a fresh edge
    task automatic issue(input crs_exec_t e);
        @(posedge CLK);
        EXEC <= e;
        @(posedge CLK);
        EXEC <= '0;
    endtask : issue

    // alu outcome; the instruction picks which flags it touches
    task automatic alu(input logic [7:0] r, input logic c,
                       input logic zu, input logic cu);
        crs_exec_t e;
        e = '0;
        e.alu_valid = 1'b1;
        e.zero_upd = zu;
        e.carry_upd = cu;
        e.alu_result = r;
        e.alu_carry = c;
        issue(e);
    endtask : alu

    // enable and bank bits move only through this logical flag write
    task automatic flag_write(input logic [7:0] v);
        crs_exec_t e;
        e = '0;
        e.flag_we = 1'b1;
        e.flag_value = v;
        issue(e);
    endtask : flag_write

    // level inputs change just after an edge
    task automatic set_mode(input logic s, input logic [7:0] op);
        @(posedge CLK);
        SUPERVISOR <= s;
        OPERAND <= op;
    endtask : set_mode
endmodule : crs_exec_model
`default_nettype wire
